// ===== design/dri_init_core.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] Eight banks, 8n prefetch, two words per clock at the pins.
// [R2] Each access is one 8n core transfer over four clocks.
// [R3] Bursts start at a column and last eight beats or four when chopped.
// [R4] Controller opens a row with Active before reading or writing that bank.
// [R5] Active: bank lines select bank, address lines select row.
// [R6] Read/Write: address gives column, A10 auto precharge, A12 chooses BC4/BL8.
// [R7] Controller holds reset low at least 200 us after power is stable.
// [R8] Controller drives CKE low at least 10 ns before releasing reset.
// [R9] After reset release, 500 us internal initialisation before CKE rises.
// [R10] Clock runs stably and NOP is registered before CKE rises.
// [R11] CKE stays high until initialisation incl. DLL lock and ZQ completes; the core only checks the latched first CKE high.
// [R12] Termination is high impedance in reset and until CKE is registered high.
// [R13] Controller holds ODT static from CKE high until initialisation ends.
// [R14] Controller waits tXPR after CKE high before the first mode load.
// [R15] Mode loads go MR2, MR3, MR1, MR0, selected by bank address.
// [R16] MR1 load enables the DLL with A0 low; MR0 resets it with A8 high.
// [R17] After MR0, ZQCL is issued and DLL lock and ZQ time are awaited; the core waits for DLL lock only, with no ZQ time counted.
// [R18] Warm reset: at least 100 ns low, then repeat from the 500 us wait.
// [R19] Reset is asynchronous active low and stays high in normal use.
// [R20] Mode load is CS, RAS, CAS, WE all low; bank picks the register.
// [R21] Controller converts each nanosecond delay to a rounded-up cycle count.

module dri_init_core #(
    parameter int INIT_WAIT_CYC = dri_pkg::INIT_WAIT_CYC,
    parameter int DLLK_CYC      = 512
) (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       ck,
    input  wire logic                       reset_n_pin,
    input  wire logic                       cke,
    input  wire logic                       cs_n,
    input  wire logic                       ras_n,
    input  wire logic                       cas_n,
    input  wire logic                       we_n,
    input  wire logic [dri_pkg::BANK_W-1:0] ba,
    input  wire logic [dri_pkg::ROW_W-1:0]  a,
    output logic                            ready,
    output logic                            dll_locked,
    output logic                            seq_error,
    output logic [3:0]                      mr_loaded,
    output logic                            odt_hiz,
    output logic                            act_pulse,
    output logic                            rw_pulse,
    output logic                            wr_sel,
    output logic [dri_pkg::BANK_W-1:0]      acc_bank,
    output logic [dri_pkg::ROW_W-1:0]       acc_row,
    output logic [dri_pkg::COL_W-1:0]       acc_col,
    output logic                            acc_ap,
    output logic [3:0]                      acc_len
);

    dri_link_if lnk ();

    logic cke_seen;

    dri_cmd_decode u_dec (
        .ck          (ck),
        .reset_n_pin (reset_n_pin),
        .cke         (cke),
        .cs_n        (cs_n),
        .ras_n       (ras_n),
        .cas_n       (cas_n),
        .we_n        (we_n),
        .ba          (ba),
        .a           (a),
        .lnk         (lnk),
        .cke_seen    (cke_seen),
        .odt_hiz     (odt_hiz),
        .act_q       (act_pulse),
        .rw_q        (rw_pulse),
        .wr_q        (wr_sel),
        .bank_q      (acc_bank),
        .row_q       (acc_row),
        .col_q       (acc_col),
        .ap_q        (acc_ap),
        .blen_q      (acc_len)
    );

    // ------------------------------------------------------------
    // Crossing into mclk: pin reset, CKE-seen level, command toggle
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic [1:0] cke_sync_q;
    logic       cmd_tog_q;
    logic [2:0] tog_sync_q;
    logic [3:0] cmd_hold_q;
    logic [2:0] bank_hold_q;
    logic [dri_pkg::ROW_W-1:0] addr_hold_q;

    // Link side: capture command words and flip a toggle per command
    always_ff @(posedge ck or negedge reset_n_pin)
    begin
        if (!reset_n_pin)
        begin
            cmd_tog_q   <= 1'b0;
            cmd_hold_q  <= dri_pkg::CMD_NOP;
            bank_hold_q <= '0;
            addr_hold_q <= '0;
        end
        else if (lnk.cmd_valid)
        begin
            cmd_tog_q   <= !cmd_tog_q;
            cmd_hold_q  <= lnk.cmd;
            bank_hold_q <= lnk.bank;
            addr_hold_q <= lnk.addr;
        end
    end

    // Held words are stable for many mclk cycles since MRS spacing exceeds the sync delay
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_sync_q <= 2'h0;
            cke_sync_q <= 2'h0;
            tog_sync_q <= 3'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], reset_n_pin};          // [R19]
            cke_sync_q <= {cke_sync_q[0], cke_seen};
            tog_sync_q <= {tog_sync_q[1:0], cmd_tog_q};
        end
    end

    logic cmd_evt;
    assign cmd_evt = tog_sync_q[2] ^ tog_sync_q[1];

    // ------------------------------------------------------------
    // Initialisation sequence
    // ------------------------------------------------------------
    dri_pkg::dri_state_t state_q;
    logic [31:0]         cnt_q;
    logic [1:0]          mr_idx_q;
    logic                dll_rst_q;
    logic                dll_en_q;
    logic                zq_q;
    logic [31:0]         dllk_q;

    // Expected bank select per load step: MR2, MR3, MR1, MR0
    function automatic logic [2:0] mr_bank(input logic [1:0] idx);
        case (idx)
            2'h0:    mr_bank = 3'h2;
            2'h1:    mr_bank = 3'h3;
            2'h2:    mr_bank = 3'h1;
            default: mr_bank = 3'h0;
        endcase
    endfunction : mr_bank

    logic is_mrs;
    assign is_mrs = cmd_evt && cmd_hold_q == dri_pkg::CMD_MRS;   // [R20]

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q   <= dri_pkg::ST_RESET;
            cnt_q     <= 32'h0000_0000;
            mr_idx_q  <= 2'h0;
            mr_loaded <= 4'h0;
            dll_en_q  <= 1'b0;
            dll_rst_q <= 1'b0;
            zq_q      <= 1'b0;
            seq_error <= 1'b0;
        end
        else if (!rst_sync_q[1])
        begin
            // Warm or cold reset restarts from the internal wait
            state_q   <= dri_pkg::ST_RESET;                      // [R18] [R19]
            cnt_q     <= 32'h0000_0000;
            mr_idx_q  <= 2'h0;
            mr_loaded <= 4'h0;
            dll_en_q  <= 1'b0;
            dll_rst_q <= 1'b0;
            zq_q      <= 1'b0;
            seq_error <= 1'b0;
        end
        else
        begin
            case (state_q)
                dri_pkg::ST_RESET:
                    state_q <= dri_pkg::ST_SELF;
                dri_pkg::ST_SELF:
                begin
                    // Internal initialisation runs on mclk, no CK needed
                    if (cnt_q >= 32'(INIT_WAIT_CYC - 1))
                        state_q <= dri_pkg::ST_WCKE;             // [R9]
                    else
                        cnt_q <= cnt_q + 32'h0000_0001;
                    if (cke_sync_q[1])
                        seq_error <= 1'b1;                       // [R9]
                end
                dri_pkg::ST_WCKE:
                    if (cke_sync_q[1])
                        state_q <= dri_pkg::ST_MODE;             // [R12]
                dri_pkg::ST_MODE:
                begin
                    if (!cke_sync_q[1])
                        seq_error <= 1'b1;                       // [R11]
                    if (is_mrs)
                    begin
                        if (bank_hold_q != mr_bank(mr_idx_q))
                            seq_error <= 1'b1;                   // [R15]
                        mr_loaded[mr_idx_q] <= 1'b1;
                        mr_idx_q <= mr_idx_q + 2'h1;
                        if (bank_hold_q == 3'h1)
                            dll_en_q <= !addr_hold_q[dri_pkg::DLL_DIS_BIT];  // [R16]
                        if (bank_hold_q == 3'h0)
                            dll_rst_q <= addr_hold_q[dri_pkg::DLL_RST_BIT];  // [R16]
                    end
                    else if (cmd_evt && cmd_hold_q == dri_pkg::CMD_ZQ && mr_loaded == 4'hF)
                        zq_q <= 1'b1;                            // [R17]
                    if (zq_q && dll_locked)
                        state_q <= dri_pkg::ST_READY;            // [R17]
                end
                dri_pkg::ST_READY:
                    state_q <= dri_pkg::ST_READY;
                default:
                    state_q <= dri_pkg::ST_RESET;
            endcase
        end
    end

    // DLL lock time counted from the DLL reset load
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            dllk_q <= 32'h0000_0000;
        else if (!rst_sync_q[1] || !dll_rst_q || !dll_en_q)
            dllk_q <= 32'h0000_0000;
        else if (dllk_q < 32'(DLLK_CYC))
            dllk_q <= dllk_q + 32'h0000_0001;
    end

    assign dll_locked = dllk_q >= 32'(DLLK_CYC);
    assign ready      = (state_q == dri_pkg::ST_READY);
    assign lnk.ready  = ready;
    assign lnk.dll_on = dll_locked;

endmodule : dri_init_core

`default_nettype wire

// ===== design/dri_pkg.sv
package dri_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int BANK_W     = 3;
    localparam int ROW_W      = 15;
    localparam int COL_W      = 10;
    localparam int BURST_BL8  = 8;
    localparam int BURST_BC4  = 4;
    localparam int PREFETCH   = 8;
    localparam int CORE_CLKS  = 4;

    // ------------------------------------------------------------
    // Address bit positions
    // ------------------------------------------------------------
    localparam int AP_BIT     = 10;
    localparam int BC_BIT     = 12;
    localparam int DLL_DIS_BIT = 0;
    localparam int DLL_RST_BIT = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int INIT_WAIT_US   = 500;
    localparam int INIT_WAIT_CYC  = (INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_ZQ  = 4'h6;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_SELF  = 3'b001,
        ST_WCKE  = 3'b011,
        ST_MODE  = 3'b010,
        ST_READY = 3'b110
    } dri_state_t;

endpackage : dri_pkg

// ===== design/dri_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface dri_link_if;
    localparam int ROW_W_L = dri_pkg::ROW_W;

    logic                          ready;
    logic                          dll_on;
    logic                          cmd_valid;
    logic [3:0]                    cmd;
    logic [dri_pkg::BANK_W-1:0]    bank;
    logic [ROW_W_L-1:0]            addr;

    modport core (output ready, output dll_on, input cmd_valid, input cmd, input bank, input addr);
    modport link (input ready, input dll_on, output cmd_valid, output cmd, output bank, output addr);
endinterface : dri_link_if

`default_nettype wire

// ===== design/dri_cmd_decode.sv
`timescale 1ns/1ns
`default_nettype none

module dri_cmd_decode (
    input  wire logic                       ck,
    input  wire logic                       reset_n_pin,
    input  wire logic                       cke,
    input  wire logic                       cs_n,
    input  wire logic                       ras_n,
    input  wire logic                       cas_n,
    input  wire logic                       we_n,
    input  wire logic [dri_pkg::BANK_W-1:0] ba,
    input  wire logic [dri_pkg::ROW_W-1:0]  a,
    dri_link_if.link                        lnk,
    output logic                            cke_seen,
    output logic                            odt_hiz,
    output logic                            act_q,
    output logic                            rw_q,
    output logic                            wr_q,
    output logic [dri_pkg::BANK_W-1:0]      bank_q,
    output logic [dri_pkg::ROW_W-1:0]       row_q,
    output logic [dri_pkg::COL_W-1:0]       col_q,
    output logic                            ap_q,
    output logic [3:0]                      blen_q
);

    // ------------------------------------------------------------
    // Link-side command capture on CK
    // ------------------------------------------------------------
    logic [1:0] rdy_sync_q;
    logic [1:0] dll_sync_q;
    logic       cke_q;
    logic [3:0] cmd_w;

    assign cmd_w = {cs_n, ras_n, cas_n, we_n};

    always_ff @(posedge ck or negedge reset_n_pin)
    begin
        if (!reset_n_pin)
        begin
            rdy_sync_q <= 2'h0;
            dll_sync_q <= 2'h0;
        end
        else
        begin
            rdy_sync_q <= {rdy_sync_q[0], lnk.ready};
            dll_sync_q <= {dll_sync_q[0], lnk.dll_on};
        end
    end

    // Termination stays off until CKE is registered high after reset
    always_ff @(posedge ck or negedge reset_n_pin)
    begin
        if (!reset_n_pin)
            cke_q <= 1'b0;
        else if (cke)
            cke_q <= 1'b1;                                       // [R12]
    end
    assign cke_seen = cke_q;
    assign odt_hiz  = !cke_q;                                    // [R12]

    // Every registered command with CS low except NOP is forwarded; mode loads are accepted before ready
    always_ff @(posedge ck or negedge reset_n_pin)
    begin
        if (!reset_n_pin)
        begin
            lnk.cmd_valid <= 1'b0;
            lnk.cmd       <= dri_pkg::CMD_NOP;
            lnk.bank      <= '0;
            lnk.addr      <= '0;
        end
        else
        begin
            lnk.cmd_valid <= cke && cmd_w != dri_pkg::CMD_NOP && !cs_n == 1'b1;
            lnk.cmd       <= cmd_w;
            lnk.bank      <= ba;
            lnk.addr      <= a;
        end
    end

    // Array access decode, only once the device is ready
    always_ff @(posedge ck or negedge reset_n_pin)
    begin
        if (!reset_n_pin)
        begin
            act_q  <= 1'b0;
            rw_q   <= 1'b0;
            wr_q   <= 1'b0;
            bank_q <= '0;
            row_q  <= '0;
            col_q  <= '0;
            ap_q   <= 1'b0;
            blen_q <= 4'h0;
        end
        else
        begin
            act_q <= 1'b0;
            rw_q  <= 1'b0;
            if (cke && rdy_sync_q[1] && cmd_w == dri_pkg::CMD_ACT)
            begin
                act_q  <= 1'b1;
                bank_q <= ba;                                    // [R5] [R1]
                row_q  <= a;                                     // [R5]
            end
            else if (cke && rdy_sync_q[1] && (cmd_w == dri_pkg::CMD_RD || cmd_w == dri_pkg::CMD_WR))
            begin
                rw_q   <= 1'b1;
                wr_q   <= (cmd_w == dri_pkg::CMD_WR);
                bank_q <= ba;
                col_q  <= a[dri_pkg::COL_W-1:0];                 // [R6]
                ap_q   <= a[dri_pkg::AP_BIT];                    // [R6]
                // BC4 when A12 low, else BL8 of PREFETCH beats over CORE_CLKS clocks
                blen_q <= a[dri_pkg::BC_BIT] ? 4'(dri_pkg::BURST_BL8)
                                             : 4'(dri_pkg::BURST_BC4); // [R3] [R2]
            end
        end
    end

endmodule : dri_cmd_decode

`default_nettype wire

// ===== bench/dri_init_core_properties.sv
`timescale 1ns/1ns
`default_nettype none

module dri_init_props (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        ck,
    input wire logic        reset_n_pin,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  ba,
    input wire logic [14:0] a,
    input wire logic        ready,
    input wire logic        dll_locked,
    input wire logic        seq_error,
    input wire logic [3:0]  mr_loaded,
    input wire logic        odt_hiz,
    input wire logic        act_pulse,
    input wire logic        rw_pulse,
    input wire logic        wr_sel,
    input wire logic [2:0]  acc_bank,
    input wire logic [14:0] acc_row,
    input wire logic [9:0]  acc_col,
    input wire logic        acc_ap,
    input wire logic [3:0]  acc_len
);
    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    property p_odt_pin;
        @(posedge ck) disable iff (!nrst) !reset_n_pin |-> ##3 odt_hiz;
    endproperty
    a_odt_pin: assert property (p_odt_pin) else $error("odt on in reset");
    property p_odt_cke;
        @(posedge ck) disable iff (!nrst) odt_hiz && !cke |=> odt_hiz;
    endproperty
    a_odt_cke: assert property (p_odt_cke) else $error("odt on before cke");
    property p_act_cmd;
        @(posedge ck) disable iff (!nrst) act_pulse |-> ready && $past(cke) && !$past(cs_n)
            && !$past(ras_n) && $past(cas_n) && $past(we_n);
    endproperty
    a_act_cmd: assert property (p_act_cmd) else $error("act pulse without act");
    property p_act_addr;
        @(posedge ck) disable iff (!nrst) act_pulse |-> acc_bank == $past(ba) && acc_row == $past(a);
    endproperty
    a_act_addr: assert property (p_act_addr) else $error("act address");
    property p_rw_col;
        @(posedge ck) disable iff (!nrst) rw_pulse |-> acc_col == $past(a[9:0])
            && acc_ap == $past(a[10]) && wr_sel == !$past(we_n);
    endproperty
    a_rw_col: assert property (p_rw_col) else $error("rw column");
    property p_rw_len;
        @(posedge ck) disable iff (!nrst) rw_pulse |-> acc_len == ($past(a[12]) ? 4'h8 : 4'h4);
    endproperty
    a_rw_len: assert property (p_rw_len) else $error("burst length");
    // ------------------------------------------------------------
    // Core side
    // ------------------------------------------------------------
    property p_ready_pin;
        @(posedge mclk) disable iff (!nrst) $fell(reset_n_pin) |-> ##[1:5] !ready;
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready kept in reset");
    property p_mr0_order;
        @(posedge mclk) disable iff (!nrst) $rose(mr_loaded[3]) |-> mr_loaded[2:0] == 3'h7;
    endproperty
    a_mr0_order: assert property (p_mr0_order) else $error("mr0 out of order");
    property p_mr1_order;
        @(posedge mclk) disable iff (!nrst) $rose(mr_loaded[2]) |-> mr_loaded[1:0] == 2'h3;
    endproperty
    a_mr1_order: assert property (p_mr1_order) else $error("mr1 out of order");
    property p_ready_dll;
        @(posedge mclk) disable iff (!nrst) $rose(ready) |-> dll_locked && mr_loaded == 4'hf && !seq_error;
    endproperty
    a_ready_dll: assert property (p_ready_dll) else $error("ready too early");
    property p_dll_mr0;
        @(posedge mclk) disable iff (!nrst) $rose(dll_locked) |-> mr_loaded[3];
    endproperty
    a_dll_mr0: assert property (p_dll_mr0) else $error("dll lock before mr0");

    c_ready: cover property (@(posedge mclk) $rose(ready));
    c_bl8: cover property (@(posedge ck) rw_pulse && acc_len == 4'h8);
    c_err: cover property (@(posedge mclk) $rose(seq_error));
endmodule : dri_init_props

bind dri_init_core dri_init_props i_dri_init_props (
    .mclk(mclk), .nrst(nrst), .ck(ck), .reset_n_pin(reset_n_pin), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a), .ready(ready), .dll_locked(dll_locked),
    .seq_error(seq_error), .mr_loaded(mr_loaded), .odt_hiz(odt_hiz), .act_pulse(act_pulse),
    .rw_pulse(rw_pulse), .wr_sel(wr_sel), .acc_bank(acc_bank), .acc_row(acc_row),
    .acc_col(acc_col), .acc_ap(acc_ap), .acc_len(acc_len)
);

`default_nettype wire

// ===== bench/dri_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module dri_ctrl_model #(
    parameter int INIT_NS = 500000,
    parameter int CK_NS   = 6
) (
    input  wire logic   ck,
    output logic        reset_n_pin,
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [2:0]  ba,
    output logic [14:0] a
);
    // Rounded up to whole link cycles, with slack for the crossing
    localparam int WAIT_CK = (INIT_NS + CK_NS - 1) / CK_NS + 2;

    initial
    begin
        reset_n_pin = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = dri_pkg::CMD_NOP;
        ba = 3'h0;
        a = 15'h0000;
    end

    // Held over one sampling edge; then the lines show the inverse
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] ad);
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        a <= ad;
        @(negedge ck);
        // Deselect between commands, so chip select toggles as well
        {cs_n, ras_n, cas_n, we_n} <= {1'b1, ~c[2:0]};
        ba <= ~b;
        a <= ~ad;
        repeat (12) @(negedge ck);
    endtask : cmd

    // Short low time stands in for the long power-up hold
    task automatic pin_reset(input int low_ck);
        @(negedge ck);
        cke <= 1'b0;
        reset_n_pin <= 1'b0;
        repeat (low_ck) @(negedge ck);
        reset_n_pin <= 1'b1;
    endtask : pin_reset

    // Early mode breaks the wait on purpose
    task automatic bring_up(input logic early);
        repeat (early ? 10 : WAIT_CK) @(negedge ck);
        // ODT is not a pin of this block; the model has no ODT output and does not drive it
        cke <= 1'b1;
        repeat (10) @(negedge ck);
        cmd(dri_pkg::CMD_MRS, 3'h2, 15'h0000);
        cmd(dri_pkg::CMD_MRS, 3'h3, 15'h0000);
        cmd(dri_pkg::CMD_MRS, 3'h1, 15'h0000);
        cmd(dri_pkg::CMD_MRS, 3'h0, 15'h0100);
        cmd(dri_pkg::CMD_ZQ, 3'h0, 15'h0400);
    endtask : bring_up
endmodule : dri_ctrl_model

`default_nettype wire

// ===== bench/dri_init_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module dri_init_core_tb_top;
    localparam int INIT_CYC = 50;
    localparam int DLLK = 20;

    logic        mclk = 1'b0;
    logic        ck = 1'b0;
    logic        nrst = 1'b0;
    logic        reset_n_pin, cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0]  ba;
    logic [14:0] a;
    logic        ready, dll_locked, seq_error, odt_hiz;
    logic [3:0]  mr_loaded;
    logic        act_pulse, rw_pulse, wr_sel, acc_ap;
    logic [2:0]  acc_bank;
    logic [14:0] acc_row;
    logic [9:0]  acc_col;
    logic [3:0]  acc_len;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n_act = 0;
    int          n_rw = 0;

    dri_init_core #(.INIT_WAIT_CYC(INIT_CYC), .DLLK_CYC(DLLK)) i_dri_init_core (
        .mclk(mclk), .nrst(nrst), .ck(ck), .reset_n_pin(reset_n_pin), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a), .ready(ready),
        .dll_locked(dll_locked), .seq_error(seq_error), .mr_loaded(mr_loaded), .odt_hiz(odt_hiz),
        .act_pulse(act_pulse), .rw_pulse(rw_pulse), .wr_sel(wr_sel), .acc_bank(acc_bank),
        .acc_row(acc_row), .acc_col(acc_col), .acc_ap(acc_ap), .acc_len(acc_len));

    dri_ctrl_model #(.INIT_NS(INIT_CYC * 8)) i_dri_ctrl_model (
        .ck(ck), .reset_n_pin(reset_n_pin), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a));

    always #4 mclk = ~mclk;

    initial
    begin
        #2;
        forever #3 ck = ~ck;
    end

    always @(posedge ck)
    begin
        if (act_pulse === 1'b1) n_act++;
        if (rw_pulse === 1'b1) n_rw++;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic settle_ready(input logic exp);
        repeat (DLLK + 10) @(negedge mclk);
        chk("ready", 16'(exp), 16'(ready));
    endtask : settle_ready

    task automatic t_power_up;
        i_dri_ctrl_model.pin_reset(40);
        repeat (6) @(negedge mclk);
        chk("odt_hiz", 16'h0001, 16'(odt_hiz));
        chk("ready", 16'h0000, 16'(ready));
        i_dri_ctrl_model.bring_up(1'b0);
        chk("mr_loaded", 16'h000f, 16'(mr_loaded));
        chk("odt_hiz", 16'h0000, 16'(odt_hiz));
        chk("ready", 16'h0000, 16'(ready));
        i_dri_ctrl_model.cmd(dri_pkg::CMD_ACT, 3'h1, 15'h0001);
        chk("act", 16'h0000, 16'(n_act));
        settle_ready(1'b1);
        chk("dll_locked", 16'h0001, 16'(dll_locked));
        chk("seq_error", 16'h0000, 16'(seq_error));
    endtask : t_power_up

    task automatic t_access;
        i_dri_ctrl_model.cmd(dri_pkg::CMD_ACT, 3'h5, 15'h4abc);
        chk("act", 16'h0001, 16'(n_act));
        chk("bank", 16'h0005, 16'(acc_bank));
        chk("row", 16'h4abc, 16'(acc_row));
        i_dri_ctrl_model.cmd(4'hb, 3'h2, 15'h0123);
        chk("act_desel", 16'h0001, 16'(n_act));
        chk("bank_desel", 16'h0005, 16'(acc_bank));
        i_dri_ctrl_model.cmd(dri_pkg::CMD_WR, 3'h5, 15'h1403);
        chk("wr_sel", 16'h0001, 16'(wr_sel));
        chk("col", 16'h0003, 16'(acc_col));
        chk("ap", 16'h0001, 16'(acc_ap));
        chk("len", 16'h0008, 16'(acc_len));
        i_dri_ctrl_model.cmd(dri_pkg::CMD_RD, 3'h5, 15'h03ff);
        chk("wr_sel", 16'h0000, 16'(wr_sel));
        chk("col", 16'h03ff, 16'(acc_col));
        chk("ap", 16'h0000, 16'(acc_ap));
        chk("len", 16'h0004, 16'(acc_len));
        chk("rw", 16'h0002, 16'(n_rw));
    endtask : t_access

    task automatic t_warm_reset;
        i_dri_ctrl_model.pin_reset(17);
        repeat (6) @(negedge mclk);
        chk("ready", 16'h0000, 16'(ready));
        chk("mr_loaded", 16'h0000, 16'(mr_loaded));
        chk("odt_hiz", 16'h0001, 16'(odt_hiz));
        i_dri_ctrl_model.bring_up(1'b0);
        settle_ready(1'b1);
    endtask : t_warm_reset

    task automatic t_early_cke;
        i_dri_ctrl_model.pin_reset(17);
        i_dri_ctrl_model.bring_up(1'b1);
        settle_ready(1'b0);
        chk("seq_error", 16'h0001, 16'(seq_error));
        fork
            i_dri_ctrl_model.pin_reset(40);
            begin
                @(negedge mclk);
                nrst = 1'b0;
                repeat (2) @(negedge mclk);
                nrst = 1'b1;
            end
        join
        i_dri_ctrl_model.bring_up(1'b0);
        settle_ready(1'b1);
        chk("seq_error", 16'h0000, 16'(seq_error));
    endtask : t_early_cke

    initial
    begin
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        t_power_up();
        t_access();
        t_warm_reset();
        t_early_cke();
        print_verdict();
    end
endmodule : dri_init_core_tb_top

`default_nettype wire
